// ===== uart_ctrl_map.vh
// Register offsets, field positions, reset values and trigger tables
// for the serial controller. Definitions only; included by bare name.
`ifndef UART_CTRL_MAP_VH
`define UART_CTRL_MAP_VH

// Register offsets on the three address pins
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_FIFO 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5

// Line control value that opens the enhanced register
`define LCR_EFR_KEY 8'hbf

// Field positions
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
`define FCR_DMA 3
`define LCR_STOP 2
`define LCR_PEN 3
`define LCR_EVEN 4
`define LCR_FORCE 5
`define LCR_BRK 6
`define LCR_DLAB 7
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_OP1 2
`define MCR_OP2 3
`define MCR_LOOP 4
`define EFR_ENH 4
`define EFR_ARTS 6

// Reset values
`define FCR_RST 8'h00
`define LCR_RST 8'h00
`define MCR_RST 8'h00

// Trigger tables, indexed by the two-bit code
`define TX_LVL0 6'h10
`define TX_LVL1 6'h08
`define TX_LVL2 6'h18
`define TX_LVL3 6'h1e
`define RX_LVL0 6'h08
`define RX_LVL1 6'h10
`define RX_LVL2 6'h18
`define RX_LVL3 6'h1c
`define RTS_HI0 6'h10
`define RTS_HI1 6'h18
`define RTS_HI2 6'h1c
`define RTS_HI3 6'h1c
`define RTS_LO0 6'h00
`define RTS_LO1 6'h08
`define RTS_LO2 6'h10
`define RTS_LO3 6'h18

// Sixteenth-bit ticks: last tick of a bit, mid start bit, stop lengths
`define TICK_END 5'h0f
`define TICK_MID 5'h07
`define STOP_ONE_HALF 5'h17
`define STOP_TWO 5'h1f

`endif

// ===== uart_fifo_line_modem_ctrl.v
// Serial controller with FIFO, line and modem control registers.
// Assumes a host on an asynchronous 8-bit strobe bus; every pin is
// synchronised to sys_clk, so strobes must last three clocks or more.
`timescale 1ns/100ps
`include "uart_ctrl_map.vh"

// Summary of operation
// - Enable bit set, else other fields ignored
// - Receive reset clears pointers, keeps shift register
// - Transmit reset clears pointers, keeps shift register
// - DMA bit changes ready pin behaviour
// - Transmit trigger codes give 16/8/24/30
// - Transmit trigger writable only when enhanced enabled
// - Transmit interrupt on drop below or empty
// - Receive trigger codes give 8/16/24/28
// - Auto RTS hysteresis levels from receive code
// - Word length five to eight bits
// - Stop bits one, one and half, two
// - Parity appended and checked when enabled
// - Even-select chooses odd or even parity
// - Forced parity is inverse of even-select
// - Break holds transmit output low
// - Divisor access redirects data locations unless 0xbf
// - Terminal-ready pin is inverted bit
// - Request-to-send pin inverted, auto flow optional
// - First general output pin inverted
// - Second output bit gates interrupt in PC mode
// - Loopback bit selects internal loopback
// - FIFO control write-only, line and modem readable
// - Interrupt status top bits mirror FIFO enable
module uart_fifo_line_modem_ctrl
#(
  parameter DEPTH = 32,
  parameter AW = 5
)
(
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Host register bus
  input wire cs_n,
  input wire ior_n,
  input wire iow_n,
  input wire [2:0] addr,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  // Bus mode strap, high selects PC mode
  input wire pc_mode,
  // Serial line and modem outputs
  input wire rx_pin,
  output reg tx_pin,
  output reg dtr_n,
  output reg rts_n,
  output reg gp_output_one_n,
  output reg gp_output_two_n,
  // Interrupt and DMA indications
  output reg int_out,
  output reg pc_interrupt_request,
  output reg transmit_ready_pin_n,
  output reg receive_ready_pin_n
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_PAR = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;
  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] ONE = 1;

  // Pin synchronisers and strobe edge detection
  reg [15:0] pin_s1;
  reg [15:0] pin_s2;
  reg [2:0] strb_q;
  reg [10:0] ad_q;
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1 <= 16'hfffe;
      pin_s2 <= 16'hfffe;
      strb_q <= 3'h7;
      ad_q <= 11'h000;
    end
    else
    begin
      pin_s1 <= {cs_n, ior_n, iow_n, addr, data_in, rx_pin, pc_mode};
      pin_s2 <= pin_s1;
      strb_q <= pin_s2[15:13];
      ad_q <= pin_s2[12:2];
    end
  end
  wire rx_s = pin_s2[1];
  wire pcm = pin_s2[0];
  wire wr_ev = ~strb_q[2] & ~strb_q[0] & pin_s2[13];
  wire rd_ev = ~strb_q[2] & ~strb_q[1] & pin_s2[14];
  wire [2:0] a = ad_q[10:8];
  wire [7:0] d = ad_q[7:0];

  // Control registers
  reg [7:0] fifo_control_reg;
  reg [7:0] line_control_reg;
  reg [7:0] modem_control_reg;
  reg [7:0] enhanced_features_reg;
  reg [7:0] ier;
  reg [7:0] divisor_low;
  reg [7:0] divisor_high;
  wire efr_sel = line_control_reg == `LCR_EFR_KEY;
  wire dlab = line_control_reg[`LCR_DLAB] & ~efr_sel;
  wire fifo_en = fifo_control_reg[`FCR_EN];
  wire dma = fifo_control_reg[`FCR_DMA];
  wire wr_thr = wr_ev & (a == `OFS_DATA) & ~dlab;
  wire wr_ier = wr_ev & (a == `OFS_IER) & ~dlab;
  wire wr_fcr = wr_ev & (a == `OFS_FIFO) & ~efr_sel;
  wire rd_rhr = rd_ev & (a == `OFS_DATA) & ~dlab;
  wire rd_isr = rd_ev & (a == `OFS_FIFO) & ~efr_sel;
  wire rd_lsr = rd_ev & (a == `OFS_LSR);
  // A change of FIFO mode empties both FIFOs as well
  wire en_chg = wr_fcr & (d[`FCR_EN] != fifo_en);
  wire rx_clr = en_chg | (wr_fcr & d[`FCR_EN] & d[`FCR_RXRST]);
  wire tx_clr = en_chg | (wr_fcr & d[`FCR_EN] & d[`FCR_TXRST]);
  wire loopb = modem_control_reg[`MCR_LOOP];
  wire [2:0] nbm1 = {1'b1, line_control_reg[1:0]};

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fifo_control_reg <= `FCR_RST;
      line_control_reg <= `LCR_RST;
      modem_control_reg <= `MCR_RST;
      enhanced_features_reg <= 8'h00;
      ier <= 8'h00;
      divisor_low <= 8'h00;
      divisor_high <= 8'h00;
    end
    else if (wr_ev)
    begin
      case (a)
        `OFS_DATA:
          if (dlab)
            divisor_low <= d;
        `OFS_IER:
          if (dlab)
            divisor_high <= d;
          else
            ier <= d;
        `OFS_FIFO:
          if (efr_sel)
            enhanced_features_reg <= d;
          else if (d[`FCR_EN])
          begin
            // Reset bits are never stored, so they stay cleared in fifo_control_reg
            fifo_control_reg[7:6] <= d[7:6];
            if (enhanced_features_reg[`EFR_ENH])
              fifo_control_reg[5:4] <= d[5:4];
            fifo_control_reg[`FCR_DMA] <= d[`FCR_DMA];
            fifo_control_reg[`FCR_EN] <= 1'b1;
          end
          else
            fifo_control_reg[`FCR_EN] <= 1'b0;
        `OFS_LCR:
          line_control_reg <= d;
        `OFS_MCR:
          modem_control_reg <= d;
        default:
          ;
      endcase
    end
  end

  // Trigger tables
  reg [5:0] tx_lvl;
  reg [5:0] rx_lvl;
  reg [5:0] rts_hi;
  reg [5:0] rts_lo;
  always @*
  begin
    case (fifo_control_reg[5:4])
      2'h0: tx_lvl = `TX_LVL0;
      2'h1: tx_lvl = `TX_LVL1;
      2'h2: tx_lvl = `TX_LVL2;
      default: tx_lvl = `TX_LVL3;
    endcase
    case (fifo_control_reg[7:6])
      2'h0: begin rx_lvl = `RX_LVL0; rts_hi = `RTS_HI0; rts_lo = `RTS_LO0; end
      2'h1: begin rx_lvl = `RX_LVL1; rts_hi = `RTS_HI1; rts_lo = `RTS_LO1; end
      2'h2: begin rx_lvl = `RX_LVL2; rts_hi = `RTS_HI2; rts_lo = `RTS_LO2; end
      default: begin rx_lvl = `RX_LVL3; rts_hi = `RTS_HI3; rts_lo = `RTS_LO3; end
    endcase
  end
  wire [AW:0] cap = fifo_en ? FULL : ONE;
  wire [AW:0] tx_trig = fifo_en ? tx_lvl[AW:0] : ONE;
  wire [AW:0] rx_trig = fifo_en ? rx_lvl[AW:0] : ONE;

  // Parity bit for a character under the current line format
  function par_bit;
    input [7:0] c;
    input [7:0] lc;
    reg [7:0] m;
    begin
      m = 8'hff >> (3'h3 - {1'b0, lc[1:0]});
      if (lc[`LCR_FORCE])
        par_bit = ~lc[`LCR_EVEN];
      else
        par_bit = (^(c & m)) ^ ~lc[`LCR_EVEN];
    end
  endfunction

  // Baud generator, one tick per sixteenth of a bit
  reg [15:0] bcnt;
  reg tick;
  wire [15:0] div = {divisor_high, divisor_low};
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bcnt <= 16'h0000;
      tick <= 1'b0;
    end
    else if (div == 16'h0000)
    begin
      bcnt <= 16'h0000;
      tick <= 1'b0;
    end
    else if (bcnt <= 16'h0001)
    begin
      bcnt <= div;
      tick <= 1'b1;
    end
    else
    begin
      bcnt <= bcnt - 16'h0001;
      tick <= 1'b0;
    end
  end

  // Transmit FIFO
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [AW-1:0] tx_wp;
  reg [AW-1:0] tx_rp;
  reg [AW:0] tx_cnt;
  reg [2:0] tx_st;
  wire tx_push = wr_thr & (tx_cnt < cap);
  wire tx_pop = (tx_st == ST_IDLE) & tick & (tx_cnt != 0) & ~tx_clr;
  always @(posedge sys_clk)
  begin
    if (tx_push)
      tx_mem[tx_wp] <= d;
  end
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_wp <= {AW{1'b0}};
      tx_rp <= {AW{1'b0}};
      tx_cnt <= {(AW+1){1'b0}};
    end
    else if (tx_clr)
    begin
      tx_wp <= {AW{1'b0}};
      tx_rp <= {AW{1'b0}};
      tx_cnt <= {(AW+1){1'b0}};
    end
    else
    begin
      if (tx_push)
        tx_wp <= tx_wp + 1'b1;
      if (tx_pop)
        tx_rp <= tx_rp + 1'b1;
      tx_cnt <= tx_cnt + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
    end
  end

  // Transmit shift register and framing
  reg [7:0] tx_sh;
  reg tx_pb;
  reg [4:0] tt;
  reg [2:0] tbn;
  reg tx_line;
  wire [4:0] stop_end = ~line_control_reg[`LCR_STOP] ? `TICK_END :
    (line_control_reg[1:0] == 2'h0) ? `STOP_ONE_HALF : `STOP_TWO;
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_st <= ST_IDLE;
      tx_sh <= 8'h00;
      tx_pb <= 1'b0;
      tt <= 5'h00;
      tbn <= 3'h0;
      tx_line <= 1'b1;
    end
    else if (tick)
    begin
      tt <= tt + 5'h01;
      case (tx_st)
        ST_IDLE:
        begin
          tx_line <= 1'b1;
          if (tx_pop)
          begin
            tx_sh <= tx_mem[tx_rp];
            tx_pb <= par_bit(tx_mem[tx_rp], line_control_reg);
            tx_st <= ST_START;
            tt <= 5'h00;
            tx_line <= 1'b0;
          end
        end
        ST_START:
          if (tt == `TICK_END)
          begin
            tx_st <= ST_DATA;
            tt <= 5'h00;
            tbn <= 3'h0;
            tx_line <= tx_sh[0];
          end
        ST_DATA:
          if (tt == `TICK_END)
          begin
            tt <= 5'h00;
            tbn <= tbn + 3'h1;
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_line <= tx_sh[1];
            if (tbn == nbm1)
            begin
              tx_st <= line_control_reg[`LCR_PEN] ? ST_PAR : ST_STOP;
              tx_line <= line_control_reg[`LCR_PEN] ? tx_pb : 1'b1;
            end
          end
        ST_PAR:
          if (tt == `TICK_END)
          begin
            tt <= 5'h00;
            tx_st <= ST_STOP;
            tx_line <= 1'b1;
          end
        ST_STOP:
          if (tt == stop_end)
            tx_st <= ST_IDLE;
        default:
          tx_st <= ST_IDLE;
      endcase
    end
  end

  // Receiver; in loopback the transmit line feeds it directly
  reg [2:0] rx_st;
  reg [4:0] rt;
  reg [2:0] rbn;
  reg [7:0] rx_sh;
  reg rx_pe;
  reg rx_done;
  wire rx_in = loopb ? tx_line : rx_s;
  wire [7:0] rx_al = rx_sh >> (3'h7 - nbm1);
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_st <= ST_IDLE;
      rt <= 5'h00;
      rbn <= 3'h0;
      rx_sh <= 8'h00;
      rx_pe <= 1'b0;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (tick)
      begin
        rt <= rt + 5'h01;
        case (rx_st)
          ST_IDLE:
            if (!rx_in)
            begin
              rx_st <= ST_START;
              rt <= 5'h00;
              rx_pe <= 1'b0;
            end
          ST_START:
            if (rt == `TICK_MID)
            begin
              rx_st <= rx_in ? ST_IDLE : ST_DATA;
              rt <= 5'h00;
              rbn <= 3'h0;
            end
          ST_DATA:
            if (rt == `TICK_END)
            begin
              rt <= 5'h00;
              rbn <= rbn + 3'h1;
              rx_sh <= {rx_in, rx_sh[7:1]};
              if (rbn == nbm1)
                rx_st <= line_control_reg[`LCR_PEN] ? ST_PAR : ST_STOP;
            end
          ST_PAR:
            if (rt == `TICK_END)
            begin
              rt <= 5'h00;
              rx_pe <= rx_in != par_bit(rx_al, line_control_reg);
              rx_st <= ST_STOP;
            end
          ST_STOP:
            if (rt == `TICK_END)
            begin
              rx_done <= 1'b1;
              rx_st <= ST_IDLE;
            end
          default:
            rx_st <= ST_IDLE;
        endcase
      end
    end
  end

  // Two-entry buffer between receiver and receive FIFO
  reg [8:0] sk0;
  reg [8:0] sk1;
  reg [1:0] sk_n;
  reg [AW:0] rx_cnt;
  wire sk_in_rdy = sk_n != 2'h2;
  wire sk_push = rx_done & sk_in_rdy;
  wire sk_pop = (sk_n != 2'h0) & (rx_cnt < cap) & ~rx_clr;
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sk0 <= 9'h000;
      sk1 <= 9'h000;
      sk_n <= 2'h0;
    end
    else
    begin
      if (sk_pop)
        sk0 <= sk1;
      if (sk_push && ((sk_n == 2'h0) || (sk_pop && sk_n == 2'h1)))
        sk0 <= {rx_pe, rx_al};
      else if (sk_push)
        sk1 <= {rx_pe, rx_al};
      sk_n <= sk_n + {1'b0, sk_push} - {1'b0, sk_pop};
    end
  end

  // Receive FIFO
  reg [7:0] rx_mem [0:DEPTH-1];
  reg [AW-1:0] rx_wp;
  reg [AW-1:0] rx_rp;
  reg par_err;
  wire rx_pop = rd_rhr & (rx_cnt != 0);
  always @(posedge sys_clk)
  begin
    if (sk_pop)
      rx_mem[rx_wp] <= sk0[7:0];
  end
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_wp <= {AW{1'b0}};
      rx_rp <= {AW{1'b0}};
      rx_cnt <= {(AW+1){1'b0}};
      par_err <= 1'b0;
    end
    else
    begin
      if (sk_pop && sk0[8])
        par_err <= 1'b1;
      else if (rd_lsr)
        par_err <= 1'b0;
      if (rx_clr)
      begin
        rx_wp <= {AW{1'b0}};
        rx_rp <= {AW{1'b0}};
        rx_cnt <= {(AW+1){1'b0}};
      end
      else
      begin
        if (sk_pop)
          rx_wp <= rx_wp + 1'b1;
        if (rx_pop)
          rx_rp <= rx_rp + 1'b1;
        rx_cnt <= rx_cnt + {{AW{1'b0}}, sk_pop} - {{AW{1'b0}}, rx_pop};
      end
    end
  end

  // Transmit interrupt, auto RTS and DMA ready tracking
  reg [AW:0] tx_cnt_q;
  reg tx_above;
  reg tx_int;
  reg rts_hold;
  reg rx_dma_act;
  wire rx_int = ier[0] & (rx_cnt >= rx_trig);
  wire tx_pend = ier[1] & tx_int;
  wire [3:0] int_id = rx_int ? 4'h4 : tx_pend ? 4'h2 : 4'h1;
  wire tx_ev = ((tx_cnt_q >= tx_trig) & (tx_cnt < tx_trig)) |
    ((tx_cnt == 0) & (tx_cnt_q != 0) & ~tx_above) |
    (wr_ier & d[1] & ~ier[1] & (tx_cnt == 0));
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_cnt_q <= {(AW+1){1'b0}};
      tx_above <= 1'b0;
      tx_int <= 1'b0;
      rts_hold <= 1'b0;
      rx_dma_act <= 1'b0;
    end
    else
    begin
      tx_cnt_q <= tx_cnt;
      if (tx_cnt == 0)
        tx_above <= 1'b0;
      else if (tx_cnt >= tx_trig)
        tx_above <= 1'b1;
      // A new event outranks a clear in the same cycle
      if (tx_ev)
        tx_int <= 1'b1;
      else if (wr_thr || (rd_isr && int_id == 4'h2))
        tx_int <= 1'b0;
      if (!enhanced_features_reg[`EFR_ARTS])
        rts_hold <= 1'b0;
      else if (rx_cnt >= rts_hi[AW:0])
        rts_hold <= 1'b1;
      else if (rx_cnt <= rts_lo[AW:0])
        rts_hold <= 1'b0;
      if (rx_cnt == 0)
        rx_dma_act <= 1'b0;
      else if (rx_cnt >= rx_trig)
        rx_dma_act <= 1'b1;
    end
  end

  // Read data and registered pin outputs
  reg [7:0] rd_val;
  always @*
  begin
    case (a)
      `OFS_DATA: rd_val = dlab ? divisor_low : rx_mem[rx_rp];
      `OFS_IER: rd_val = dlab ? divisor_high : ier;
      `OFS_FIFO: rd_val = efr_sel ? enhanced_features_reg :
        {fifo_en, fifo_en, 2'h0, int_id};
      `OFS_LCR: rd_val = line_control_reg;
      `OFS_MCR: rd_val = modem_control_reg;
      `OFS_LSR: rd_val = {1'b0, (tx_cnt == 0) & (tx_st == ST_IDLE), tx_cnt == 0,
        2'h0, par_err, 1'b0, rx_cnt != 0};
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      tx_pin <= 1'b1;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      gp_output_one_n <= 1'b1;
      gp_output_two_n <= 1'b1;
      int_out <= 1'b0;
      pc_interrupt_request <= 1'b0;
      transmit_ready_pin_n <= 1'b1;
      receive_ready_pin_n <= 1'b1;
    end
    else
    begin
      data_out <= rd_val;
      data_oe <= ~strb_q[2] & ~strb_q[1];
      tx_pin <= loopb | (tx_line & ~line_control_reg[`LCR_BRK]);
      dtr_n <= loopb | ~modem_control_reg[`MCR_DTR];
      rts_n <= loopb | ~(modem_control_reg[`MCR_RTS] & ~rts_hold);
      gp_output_one_n <= loopb | ~modem_control_reg[`MCR_OP1];
      gp_output_two_n <= loopb | pcm | ~modem_control_reg[`MCR_OP2];
      int_out <= (int_id != 4'h1) & ~pcm;
      pc_interrupt_request <= (int_id != 4'h1) & pcm & modem_control_reg[`MCR_OP2];
      transmit_ready_pin_n <= ~(dma ? (tx_cnt < cap) : (tx_cnt == 0));
      receive_ready_pin_n <= ~(dma ? rx_dma_act : (rx_cnt != 0));
    end
  end

endmodule

// ===== fifo_ctrl_chk.sv
// Port-side checker for the serial controller.
// Assumes a host that holds each bus strobe for three clocks or more.
`timescale 1ns/100ps
module fifo_ctrl_chk
(
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Host bus
  input wire cs_n,
  input wire ior_n,
  input wire iow_n,
  input wire data_oe,
  input wire pc_mode,
  // Pins
  input wire tx_pin,
  input wire dtr_n,
  input wire rts_n,
  input wire gp_output_one_n,
  input wire gp_output_two_n,
  input wire int_out,
  input wire pc_interrupt_request
);
  reg prev_w;
  reg [3:0] since_w;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Cycles since the write strobe last ended
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_w <= 1'b1;
      since_w <= 4'hf;
    end
    else
    begin
      prev_w <= iow_n;
      if (iow_n && !prev_w)
        since_w <= 4'h0;
      else if (since_w != 4'hf)
        since_w <= since_w + 4'h1;
    end
  end

  AST_RESET_PINS: assert property (
    $rose(resetn) |-> tx_pin && dtr_n && rts_n && gp_output_one_n && !int_out)
    else $error("outputs not idle after reset");
  AST_OE_RISE: assert property (
    $rose(data_oe) |-> $past(!ior_n && !cs_n, 2))
    else $error("read data driven without a read strobe");
  AST_OE_HOLD: assert property (
    (!ior_n && !cs_n) [*4] |=> data_oe)
    else $error("read data not driven during read");
  AST_OE_DROP: assert property (
    (ior_n || cs_n) [*4] |=> !data_oe)
    else $error("read data still driven after read");
  AST_TWO_PC: assert property (
    pc_mode [*4] |-> gp_output_two_n)
    else $error("second output driven in pc mode");
  AST_REQ_BUS: assert property (
    (!pc_mode) [*4] |-> !pc_interrupt_request)
    else $error("pc request outside pc mode");
  AST_INT_PC: assert property (
    pc_mode [*4] |-> !int_out)
    else $error("bus interrupt raised in pc mode");
  AST_DTR_CAUSE: assert property (
    $changed(dtr_n) |-> since_w <= 4'h8)
    else $error("terminal ready moved without a write");
  AST_OP1_CAUSE: assert property (
    $changed(gp_output_one_n) |-> since_w <= 4'h8)
    else $error("first output moved without a write");

  cover property ($fell(tx_pin));
  cover property ($fell(dtr_n));
  cover property ($rose(pc_interrupt_request));
endmodule

bind uart_fifo_line_modem_ctrl fifo_ctrl_chk u_chk
(
  .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n),
  .data_oe(data_oe), .pc_mode(pc_mode), .tx_pin(tx_pin), .dtr_n(dtr_n), .rts_n(rts_n),
  .gp_output_one_n(gp_output_one_n), .gp_output_two_n(gp_output_two_n),
  .int_out(int_out), .pc_interrupt_request(pc_interrupt_request)
);

// ===== uart_host_model.sv
// Host processor on the 8-bit strobe bus.
// Strobes last four clocks, the bus is released between cycles.
`timescale 1ns/100ps
module uart_host_model
(
  // Clock
  input wire sys_clk,
  // Strobe bus
  output reg cs_n,
  output reg ior_n,
  output reg iow_n,
  output reg [2:0] addr,
  output reg [7:0] data_in,
  input wire [7:0] data_out
);
  initial
  begin
    cs_n = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr = 3'h7;
    data_in = 8'h00;
  end

  task wr(input [2:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    #1 addr = a;
    data_in = d;
    cs_n = 1'b0;
    iow_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 iow_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    // Released bus shows the inverse, not the stale byte
    #1 cs_n = 1'b1;
    data_in = ~d;
    addr = ~a;
    repeat (3) @(posedge sys_clk);
    #1;
  end
  endtask

  task rd(input [2:0] a, output [7:0] d);
  begin
    @(posedge sys_clk);
    #1 addr = a;
    cs_n = 1'b0;
    ior_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 d = data_out;
    ior_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 cs_n = 1'b1;
    addr = ~a;
  end
  endtask
endmodule

// ===== tb_uart_fifo_line_modem_ctrl.sv
// Testbench for the serial controller.
// Serial output is looped back to the serial input outside the block.
`timescale 1ns/100ps
module tb_uart_fifo_line_modem_ctrl;
  reg sys_clk;
  reg resetn;
  reg pc_mode;
  wire cs_n, ior_n, iow_n, data_oe, tx_pin, dtr_n, rts_n;
  wire gp_output_one_n, gp_output_two_n, int_out, pc_interrupt_request;
  wire transmit_ready_pin_n, receive_ready_pin_n;
  wire [2:0] addr;
  wire [7:0] data_in, data_out;
  integer n_fail;
  integer cmp_count;
  reg [7:0] v;
  reg [10:0] line_bits;
  integer k;

  uart_host_model host
  (
    .sys_clk(sys_clk), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n), .addr(addr),
    .data_in(data_in), .data_out(data_out)
  );

  uart_fifo_line_modem_ctrl dut
  (
    .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .pc_mode(pc_mode), .rx_pin(tx_pin), .tx_pin(tx_pin), .dtr_n(dtr_n), .rts_n(rts_n),
    .gp_output_one_n(gp_output_one_n), .gp_output_two_n(gp_output_two_n),
    .int_out(int_out), .pc_interrupt_request(pc_interrupt_request),
    .transmit_ready_pin_n(transmit_ready_pin_n), .receive_ready_pin_n(receive_ready_pin_n)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task check(input [7:0] seen, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  function [7:0] modem_pins(input dummy);
    modem_pins = {4'h0, dtr_n, rts_n, gp_output_one_n, gp_output_two_n};
  endfunction

  task finish_test;
  begin
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task t_reset;
  begin
    check({2'h0, tx_pin, dtr_n, rts_n, gp_output_one_n, gp_output_two_n, int_out}, 8'h3e);
    host.rd(3'h3, v);
    check(v, 8'h00);
    host.rd(3'h4, v);
    check(v, 8'h00);
    host.rd(3'h2, v);
    check(v & 8'hc0, 8'h00);
    $display("t_reset done");
  end
  endtask

  task t_modem;
  begin
    host.wr(3'h4, 8'h0f);
    check(modem_pins(1'b0), 8'h00);
    host.rd(3'h4, v);
    check(v, 8'h0f);
    pc_mode = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 check(modem_pins(1'b0), 8'h01);
    pc_mode = 1'b0;
    host.wr(3'h4, 8'h1f);
    check(modem_pins(1'b0), 8'h0f);
    host.wr(3'h4, 8'h06);
    check(modem_pins(1'b0), 8'h09);
    $display("t_modem done");
  end
  endtask

  task t_line;
  begin
    host.wr(3'h3, 8'h1f);
    host.rd(3'h3, v);
    check(v, 8'h1f);
    host.wr(3'h3, 8'h40);
    repeat (20) @(posedge sys_clk);
    #1 check({7'h0, tx_pin}, 8'h00);
    host.wr(3'h3, 8'h80);
    check({7'h0, tx_pin}, 8'h01);
    host.wr(3'h1, 8'h5a);
    host.rd(3'h1, v);
    check(v, 8'h5a);
    host.wr(3'h3, 8'hbf);
    host.rd(3'h1, v);
    check(v, 8'h00);
    host.wr(3'h2, 8'h10);
    host.wr(3'h3, 8'h80);
    host.wr(3'h1, 8'h00);
    host.wr(3'h3, 8'h03);
    $display("t_line done");
  end
  endtask

  task t_fifo;
  begin
    host.wr(3'h2, 8'h01);
    host.rd(3'h2, v);
    check(v & 8'hc0, 8'hc0);
    check({7'h0, transmit_ready_pin_n}, 8'h00);
    host.wr(3'h0, 8'h11);
    host.wr(3'h0, 8'h22);
    check({7'h0, transmit_ready_pin_n}, 8'h01);
    host.wr(3'h2, 8'h09);
    check({7'h0, transmit_ready_pin_n}, 8'h00);
    host.wr(3'h2, 8'h05);
    host.rd(3'h5, v);
    check(v & 8'h20, 8'h20);
    host.wr(3'h1, 8'h02);
    check({7'h0, int_out}, 8'h01);
    pc_mode = 1'b1;
    host.wr(3'h4, 8'h08);
    check({6'h0, int_out, pc_interrupt_request}, 8'h01);
    host.wr(3'h4, 8'h00);
    check({6'h0, int_out, pc_interrupt_request}, 8'h00);
    pc_mode = 1'b0;
    host.wr(3'h1, 8'h00);
    host.wr(3'h2, 8'h00);
    host.rd(3'h2, v);
    check(v & 8'hc0, 8'h00);
    host.wr(3'h2, 8'h06);
    host.rd(3'h2, v);
    check(v & 8'hc0, 8'h00);
    $display("t_fifo done");
  end
  endtask

  task xfer(input [7:0] lc, input [7:0] b, input [7:0] e, input pb);
  begin
    host.wr(3'h3, lc);
    fork
      host.wr(3'h0, b);
      begin
        // Sample the outgoing frame at mid-bit, sixteen clocks a bit
        @(negedge tx_pin);
        repeat (8) @(posedge sys_clk);
        for (k = 0; k < 11; k = k + 1)
        begin
          #1 line_bits[k] = tx_pin;
          repeat (16) @(posedge sys_clk);
        end
      end
    join
    check({7'h0, line_bits[6 + lc[1:0]]}, {7'h0, pb});
    repeat (300) @(posedge sys_clk);
    #1 check({7'h0, receive_ready_pin_n}, 8'h00);
    host.rd(3'h5, v);
    check(v & 8'h05, 8'h01);
    host.rd(3'h0, v);
    check(v, e);
  end
  endtask

  task t_serial;
  begin
    host.wr(3'h2, 8'h01);
    host.wr(3'h3, 8'h80);
    host.wr(3'h0, 8'h01);
    host.wr(3'h3, 8'h03);
    repeat (400) @(posedge sys_clk);
    host.wr(3'h2, 8'h07);
    host.rd(3'h5, v);
    check(v & 8'h01, 8'h00);
    xfer(8'h03, 8'ha5, 8'ha5, 1'b1);
    xfer(8'h1e, 8'hff, 8'h7f, 1'b1);
    xfer(8'h3b, 8'h07, 8'h07, 1'b0);
    $display("t_serial done");
  end
  endtask

  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    resetn = 1'b0;
    pc_mode = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'b1;
    t_reset;
    t_modem;
    t_line;
    t_fifo;
    t_serial;
    finish_test;
  end
endmodule
